// ### hdl/burst_sram_pkg.sv
// Shared constants and types for the burst SRAM input-capture block
package burst_sram_pkg;
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam logic [1:0] BURST_RESET = 2'h0;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;
	localparam logic [LANES-1:0] LANES_ALL = 4'hf;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;

	typedef enum logic [1:0] {
		ST_DESELECTED = 2'b00,
		ST_READ = 2'b01,
		ST_WRITE = 2'b10
	} access_state_t;
endpackage : burst_sram_pkg

// ### hdl/burst_order_if.sv
// Burst counter hand-off between control and address sequencer
`timescale 1ns/1ps
interface burst_order_if;
	logic [1:0] start_offset;
	logic [1:0] count;
	logic interleaved;
	logic [1:0] offset;

	modport ctrl (output start_offset, output count, output interleaved,
		input offset);
	modport seq (input start_offset, input count, input interleaved,
		output offset);
endinterface : burst_order_if

// ### hdl/burst_order_seq.sv
// Combines burst start bits with the burst count in linear or interleaved order
`timescale 1ns/1ps
module burst_order_seq (
	burst_order_if.seq bo // Counter in, low address bits out
);
	always_comb begin
		if (bo.interleaved) begin
			bo.offset = bo.start_offset ^ bo.count;
		end else begin
			bo.offset = bo.start_offset + bo.count;
		end
	end
endmodule : burst_order_seq

// ### hdl/burst_sram_input_ctrl.sv
// Synchronous input capture and burst control for a flow-through burst SRAM
`timescale 1ns/1ps
module burst_sram_input_ctrl (
	input wire logic ref_clk_i, // 50 MHz clock
	input wire logic rst_n_i, // Synchronous reset, active low
	input wire logic [burst_sram_pkg::ADDR_W-1:0] addr_i, // Address bus
	input wire logic processor_address_strobe_n_i, // Active low
	input wire logic controller_address_strobe_n_i, // Active low
	input wire logic burst_advance_n_i, // Active low
	input wire logic primary_chip_select_n_i, // Active low
	input wire logic high_true_chip_select_i, // Active high
	input wire logic third_chip_select_n_i, // Active low
	input wire logic byte_write_gate_n_i, // Active low
	input wire logic [burst_sram_pkg::LANES-1:0] byte_lane_write_select_n_i,
	input wire logic all_bytes_write_n_i, // Active low
	input wire logic sequence_select_i, // High interleaved, low linear
	output logic [burst_sram_pkg::ADDR_W-1:0] mem_addr_o, // Access address
	output logic access_valid_o, // An access this cycle
	output logic access_write_o, // Access is a write
	output logic [burst_sram_pkg::LANES-1:0] lane_write_o, // Lanes written
	output logic selected_o // Device selected
);
	burst_order_if bo ();

	burst_order_seq u_seq (
		.bo(bo.seq)
	);

	// Registered input stage, every input except sequence_select_i sampled on the rising edge
	logic [burst_sram_pkg::ADDR_W-1:0] addr_s_reg;
	logic processor_address_strobe_s_reg, controller_address_strobe_s_reg, adv_s_reg;
	logic ce1_s_reg, ce2_s_reg, ce3_s_reg;
	logic gate_s_reg, all_s_reg;
	logic [burst_sram_pkg::LANES-1:0] sel_s_reg;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			addr_s_reg <= burst_sram_pkg::ADDR_RESET;
			processor_address_strobe_s_reg <= 1'b1;
			controller_address_strobe_s_reg <= 1'b1;
			adv_s_reg <= 1'b1;
			ce1_s_reg <= 1'b1;
			ce2_s_reg <= 1'b0;
			ce3_s_reg <= 1'b1;
			gate_s_reg <= 1'b1;
			all_s_reg <= 1'b1;
			sel_s_reg <= burst_sram_pkg::LANES_ALL;
		end else begin
			addr_s_reg <= addr_i;
			processor_address_strobe_s_reg <= processor_address_strobe_n_i;
			controller_address_strobe_s_reg <= controller_address_strobe_n_i;
			adv_s_reg <= burst_advance_n_i;
			ce1_s_reg <= primary_chip_select_n_i;
			ce2_s_reg <= high_true_chip_select_i;
			ce3_s_reg <= third_chip_select_n_i;
			gate_s_reg <= byte_write_gate_n_i;
			all_s_reg <= all_bytes_write_n_i;
			sel_s_reg <= byte_lane_write_select_n_i;
		end
	end

	function automatic logic [burst_sram_pkg::LANES-1:0] lane_mask(
		input logic all_n,
		input logic gate_n,
		input logic [burst_sram_pkg::LANES-1:0] sel_n
	);
		if (!all_n) begin
			lane_mask = burst_sram_pkg::LANES_ALL;
		end else if (!gate_n) begin
			lane_mask = ~sel_n;
		end else begin
			lane_mask = burst_sram_pkg::LANES_NONE;
		end
	endfunction : lane_mask

	burst_sram_pkg::access_state_t state_reg, state_next;
	logic [burst_sram_pkg::ADDR_W-1:0] base_reg, base_next;
	logic [1:0] count_reg, count_next;
	logic interleaved_reg, interleaved_next;
	logic [burst_sram_pkg::ADDR_W-1:0] mem_addr_next;
	logic valid_next, write_next;
	logic [burst_sram_pkg::LANES-1:0] lanes_next;
	logic processor_address_strobe_hit, controller_address_strobe_hit, load, enables_ok;
	logic [burst_sram_pkg::LANES-1:0] mask_now;

	assign bo.start_offset = base_reg[1:0];
	assign bo.count = count_reg;
	assign bo.interleaved = interleaved_reg;

	always_comb begin
		// Chip selects are combined here, gated by a strobe; the primary select also qualifies the processor strobe
		enables_ok = !ce1_s_reg && ce2_s_reg && !ce3_s_reg;
		processor_address_strobe_hit = !processor_address_strobe_s_reg && !ce1_s_reg;
		// Processor strobe pre-empts controller strobe
		// An ignored processor strobe leaves the controller strobe in charge
		controller_address_strobe_hit = !controller_address_strobe_s_reg && !processor_address_strobe_hit;
		load = processor_address_strobe_hit || controller_address_strobe_hit;
		mask_now = lane_mask(all_s_reg, gate_s_reg, sel_s_reg);
		state_next = state_reg;
		base_next = base_reg;
		count_next = count_reg;
		interleaved_next = interleaved_reg;
		valid_next = 1'b0;
		write_next = 1'b0;
		lanes_next = burst_sram_pkg::LANES_NONE;
		mem_addr_next = {base_reg[burst_sram_pkg::ADDR_W-1:2], bo.offset};
		if (load) begin
			if (enables_ok) begin
				base_next = addr_s_reg;
				count_next = burst_sram_pkg::BURST_RESET;
				interleaved_next = sequence_select_i;
				mem_addr_next = addr_s_reg;
				valid_next = 1'b1;
				// Processor-strobe cycles are always reads; write follows
				if (controller_address_strobe_hit && mask_now != burst_sram_pkg::LANES_NONE) begin
					state_next = burst_sram_pkg::ST_WRITE;
					write_next = 1'b1;
					lanes_next = mask_now;
				end else begin
					state_next = burst_sram_pkg::ST_READ;
				end
			end else begin
				state_next = burst_sram_pkg::ST_DESELECTED;
			end
		end else begin
			case (state_reg)
				burst_sram_pkg::ST_DESELECTED: begin
					valid_next = 1'b0;
				end
				default: begin
					// Counter wraps inside the 4-beat block
					if (!adv_s_reg) begin
						count_next = count_reg + 2'h1;
					end
					mem_addr_next = {base_reg[burst_sram_pkg::ADDR_W-1:2],
						count_next ^ (interleaved_reg ? base_reg[1:0] : 2'h0)};
					if (!interleaved_reg) begin
						mem_addr_next[1:0] = base_reg[1:0] + count_next;
					end
					valid_next = 1'b1;
					if (mask_now != burst_sram_pkg::LANES_NONE) begin
						state_next = burst_sram_pkg::ST_WRITE;
						write_next = 1'b1;
						lanes_next = mask_now;
					end else begin
						state_next = burst_sram_pkg::ST_READ;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= burst_sram_pkg::ST_DESELECTED;
			base_reg <= burst_sram_pkg::ADDR_RESET;
			count_reg <= burst_sram_pkg::BURST_RESET;
			interleaved_reg <= 1'b0;
			mem_addr_o <= burst_sram_pkg::ADDR_RESET;
			access_valid_o <= 1'b0;
			access_write_o <= 1'b0;
			lane_write_o <= burst_sram_pkg::LANES_NONE;
			selected_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			base_reg <= base_next;
			count_reg <= count_next;
			interleaved_reg <= interleaved_next;
			mem_addr_o <= mem_addr_next;
			access_valid_o <= valid_next;
			access_write_o <= write_next;
			lane_write_o <= lanes_next;
			selected_o <= state_next != burst_sram_pkg::ST_DESELECTED;
		end
	end
endmodule : burst_sram_input_ctrl

// ### tb/burst_sram_props_properties.sv
// Port-level checker for capture, burst order and write lanes
`timescale 1ns/1ps
module burst_sram_props (
	input logic ref_clk_i, rst_n_i, // Clock and reset
	input logic [burst_sram_pkg::ADDR_W-1:0] addr_i, mem_addr_o, // Addresses
	input logic processor_address_strobe_n_i, controller_address_strobe_n_i,
	input logic burst_advance_n_i, primary_chip_select_n_i,
	input logic high_true_chip_select_i, third_chip_select_n_i,
	input logic byte_write_gate_n_i, all_bytes_write_n_i, sequence_select_i,
	input logic [burst_sram_pkg::LANES-1:0] byte_lane_write_select_n_i,
	input logic [burst_sram_pkg::LANES-1:0] lane_write_o, // Lanes written
	input logic access_valid_o, access_write_o, selected_o // Status
);
	wire ps = !processor_address_strobe_n_i, cc = !controller_address_strobe_n_i;
	wire c1 = !primary_chip_select_n_i, burst_advance = !burst_advance_n_i;
	wire ok = c1 && high_true_chip_select_i && !third_chip_select_n_i;
	wire gw = !all_bytes_write_n_i, bw = !byte_write_gate_n_i;
	wire ld_c = cc && !ps; // Controller strobe counts only alone
	wire idle = !ps && !cc;
	wire v = access_valid_o, sq = sequence_select_i;
	wire [1:0] lo = mem_addr_o[1:0];
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_gw; ld_c && ok && gw |-> ##2 v && lane_write_o == 4'hf;
	endproperty
	a_gw: assert property (p_gw) else $error("lanes not all written");
	property p_bw; ld_c && ok && !gw && bw |-> ##2 v &&
		lane_write_o == ~$past(byte_lane_write_select_n_i, 2); endproperty
	a_bw: assert property (p_bw) else $error("byte lanes wrong");
	property p_rd; ps && ok |-> ##2 v && !access_write_o; endproperty
	a_rd: assert property (p_rd) else $error("processor load wrote");
	property p_ign; ps && !c1 && cc |-> ##2 !selected_o && !v; endproperty
	a_ign: assert property (p_ign) else $error("strobe not ignored");
	property p_des; (ps && c1 || cc) && !high_true_chip_select_i |->
		##2 !selected_o && !v; endproperty
	a_des: assert property (p_des) else $error("no deselect");
	property p_ld; (ps || cc) && ok |-> ##2 v &&
		mem_addr_o == $past(addr_i, 2); endproperty
	a_ld: assert property (p_ld) else $error("load address wrong");
	property p_adv; idle && burst_advance && !sq ##1 v |-> ##1 v &&
		lo == $past(lo) + 2'h1; endproperty
	a_adv: assert property (p_adv) else $error("no linear advance");
	property p_hold; idle && !burst_advance ##1 v |-> ##1 v && $stable(mem_addr_o);
	endproperty
	a_hold: assert property (p_hold) else $error("burst address moved");
	property p_ilv; (ps || cc) && ok && sq ##1 idle && burst_advance |-> ##1 v ##1
		lo == $past(lo) ^ 2'h1; endproperty
	a_ilv: assert property (p_ilv) else $error("interleave wrong");
	c_ilv: cover property ((ps || cc) && ok && sq);
	c_des: cover property (ld_c && !ok);
	c_gw: cover property (ld_c && ok && gw);
endmodule : burst_sram_props
bind burst_sram_input_ctrl burst_sram_props u_props (.*);

// ### tb/burst_bus_master.sv
// Bus-master model presenting one control cycle per clock
`timescale 1ns/1ps
module burst_bus_master (
	input wire logic ref_clk_i, // Clock
	output logic [30:0] pins_o // Address and control pins, packed
);
	initial pins_o = 31'h00001efe;
	task automatic beat(input logic [17:0] a, input logic [1:0] s,
		input logic burst_advance, input logic [2:0] ce, input logic gw,
		input logic [3:0] ln, input logic sq);
		@(posedge ref_clk_i);
		// Gate low whenever any lane is picked
		pins_o <= {a, ~s[0], ~s[1], burst_advance, ce, gw, ~|ln, ~ln, sq};
	endtask : beat
endmodule : burst_bus_master

// ### tb/sync_burst_sram_input_control_tb_top.sv
// Self-checking bench for the burst SRAM input-capture block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module sync_burst_sram_input_control_tb_top;
	logic ref_clk_i = 0, rst_n_i = 0, sel = 0, md = 0;
	logic [30:0] p;
	logic [17:0] mem_addr_o, base;
	logic access_valid_o, access_write_o, selected_o;
	logic [3:0] lane_write_o;
	logic [1:0] cnt;
	logic [22:0] q[$], x;
	int fail_count = 0, checks_done = 0, seed = 32'h96fe, n;
	burst_bus_master u_bm (.ref_clk_i(ref_clk_i), .pins_o(p));
	burst_sram_input_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.addr_i(p[30:13]), .processor_address_strobe_n_i(p[12]),
		.controller_address_strobe_n_i(p[11]), .burst_advance_n_i(p[10]),
		.primary_chip_select_n_i(p[9]), .high_true_chip_select_i(p[8]),
		.third_chip_select_n_i(p[7]), .all_bytes_write_n_i(p[6]),
		.byte_write_gate_n_i(p[5]), .byte_lane_write_select_n_i(p[4:1]),
		.sequence_select_i(p[0]), .mem_addr_o(mem_addr_o),
		.access_valid_o(access_valid_o), .access_write_o(access_write_o),
		.lane_write_o(lane_write_o), .selected_o(selected_o));
	initial forever #10 ref_clk_i = ~ref_clk_i;
	task automatic op(input logic [17:0] a, input logic [1:0] s,
		input logic burst_advance, input logic [2:0] ce, input logic gw,
		input logic [3:0] ln);
		logic pl, wr;
		pl = s[0] && !ce[2]; // Select high hides this strobe
		wr = !pl && (!gw || |ln);
		u_bm.beat(a, s, burst_advance, ce, gw, ln, md);
		if (pl || s[1]) begin
			sel = ce == 3'b010;
			base = a;
			cnt = 2'h0;
		end else if (!burst_advance) cnt++;
		if (sel) q.push_back({base[17:2], md ? base[1:0] ^ cnt :
			base[1:0] + cnt, wr, !wr ? 4'h0 : gw ? ln : 4'hf});
	endtask : op
	always @(posedge ref_clk_i) if (access_valid_o === 1'b1) begin
		if (q.size() == 0) `CHK("extra beat", 1'b0, 1'b1)
		else begin
			x = q.pop_front();
			`CHK("beat", x, {mem_addr_o, access_write_o, lane_write_o})
			`CHK("selected", 1'b1, selected_o)
		end
	end
	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			md = m[0];
			for (int i = 0; i < 80; i++) begin
				n = $random(seed);
				op(n[31:14], n[10] ? n[9:8] : 2'h0, n[11], n[4:3] != 0 ?
					3'b010 : n[7:5], n[12] | n[13], n[17:14] & {4{n[18]}});
			end
			op(18'h0, 2'h2, 1'b1, 3'b000, 1'b1, 4'h0); // Deselect
			op(18'h3, 2'h1, 1'b0, 3'b110, 1'b1, 4'h0);
			$display("test mode %0d done", m);
		end
		repeat (4) @(posedge ref_clk_i);
		`CHK("pending", 0, q.size())
		complete_run();
	end
endmodule : sync_burst_sram_input_control_tb_top
